// File: verification/exec_checker_properties.sv
// Assertion checker bound to the executor ports
`timescale 1ns/10ps
module exec_checker (
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire exec_pkg::instr_s   instr_in,
    input wire exec_pkg::file_wr_s file_wr,
    input wire logic [7:0]         work_reg,
    input wire logic               carry_flag,
    input wire logic               digit_carry_flag,
    input wire logic               zero_flag,
    input wire logic               timeout_flag_n,
    input wire logic               powerdown_flag_n,
    input wire logic [7:0]         watchdog_counter,
    input wire logic [7:0]         watchdog_prescaler,
    input wire logic               osc_run,
    input wire logic               asleep
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [7:0]  fd  = instr_in.file_data;
    wire [11:0] w   = instr_in.word;
    wire        go  = instr_in.valid && !asleep;
    wire        slp = go && w == exec_pkg::SLEEP_OPCODE;
    wire        sub = go && w[11:6] == exec_pkg::SUB_OPCODE;
    wire        swp = go && w[11:6] == exec_pkg::SWAP_OPCODE;
    wire [7:0]  dif = fd - work_reg;
    wire [7:0]  res = sub ? dif : {fd[3:0], fd[7:4]};
    wire [2:0]  fl  = {fd >= work_reg, fd[3:0] >= work_reg[3:0], dif == 8'h00};
    wire [2:0]  cur = {carry_flag, digit_carry_flag, zero_flag};
    wire [13:0] wr  = {1'b1, w[4:0], res};
    a_sleep_wdt_clear:
    assert property (slp |=> {watchdog_counter, watchdog_prescaler} == 16'h0000)
        else $error("watchdog not cleared by power-down");
    a_sleep_timeout_set:
    assert property (slp |=> timeout_flag_n) else $error("timeout flag low");
    a_sleep_pd_clear:
    assert property (slp |=> !powerdown_flag_n)
        else $error("powerdown flag high");
    a_sleep_osc_halt:
    assert property (slp |=> !osc_run && asleep)
        else $error("oscillator not halted");
    a_asleep_wdt_zero:
    assert property (asleep |-> {watchdog_counter, watchdog_prescaler} == 16'h0000)
        else $error("watchdog moved while asleep");
    a_asleep_frozen:
    assert property (asleep |=> !file_wr.file_we && $stable(work_reg))
        else $error("activity while asleep");
    a_sub_flags:
    assert property (sub |=> cur == $past(fl))
        else $error("subtract flags wrong");
    a_work_dest:
    assert property ((sub || swp) && !w[5] |=> work_reg == $past(res))
        else $error("work result wrong");
    a_file_dest:
    assert property ((sub || swp) && w[5] |=> file_wr == $past(wr))
        else $error("file write wrong");
    a_swap_flags_kept:
    assert property (swp |=> $stable(cur)) else $error("swap changed flags");
    cover property (slp);
    cover property (sub && w[5]);
    cover property (swp && !w[5]);
endmodule // exec_checker
bind sleep_subtract_swap_exec exec_checker i_exec_checker (.*);

// File: verification/test_sleep_subtract_swap_exec.sv
// Self-checking bench with an integer model of the executor
`timescale 1ns/10ps
module test_sleep_subtract_swap_exec;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    exec_pkg::instr_s   instr_in = '0;
    exec_pkg::file_wr_s file_wr;
    logic [7:0] work_reg, watchdog_counter, watchdog_prescaler;
    logic       carry_flag, digit_carry_flag, zero_flag, timeout_flag_n;
    logic       powerdown_flag_n, osc_run, asleep;
    int         fail_count = 0, checks_done = 0, wk = 0, fl = 0, slp = 0, n;
    int         ps = 0, wd = 0;
    wire [2:0]  flags = {carry_flag, digit_carry_flag, zero_flag};
    wire [3:0]  pwr = {timeout_flag_n, powerdown_flag_n, osc_run, asleep};
    always #2.5 ref_clk = ~ref_clk;
    sleep_subtract_swap_exec i_sleep_subtract_swap_exec (.*);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
                     exp);
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic run(input logic v, input logic [11:0] w,
                       input logic [7:0] f);
        int op, r, we;
        instr_in <= '{v, w, f};
        op = (!v || slp) ? 0 : (w == exec_pkg::SLEEP_OPCODE) ? 1
           : (w[11:6] == exec_pkg::SUB_OPCODE) ? 2
           : (w[11:6] == exec_pkg::SWAP_OPCODE) ? 3 : 0;
        r = (op == 2) ? (f - wk) & 255 : {f[3:0], f[7:4]};
        if (op == 1) begin
            ps = 0;
            wd = 0;
        end else if (!slp) begin
            wd = (wd + (ps == 255)) & 255;
            ps = (ps + 1) & 255;
        end
        if (op == 1) slp = 1;
        if (op == 2) fl = (f >= wk) * 4 + (f[3:0] >= wk[3:0]) * 2 + (r == 0);
        we = op > 1 && w[5];
        if (op > 1 && !w[5]) wk = r;
        @(posedge ref_clk);
        #1;
        chk(work_reg, wk);
        chk(flags, fl);
        chk(file_wr.file_we, we);
        if (we) chk(file_wr[12:0], {w[4:0], r[7:0]});
        chk(pwr, slp ? 9 : 14);
        chk({watchdog_counter, watchdog_prescaler}, wd * 256 + ps);
    endtask
    initial begin
        logic [11:0] x;
        n = $urandom(40);
        repeat (3) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        run(1, 12'h385, 8'h20);
        run(1, 12'h0A1, 8'h03);
        run(1, 12'h0A1, 8'h02);
        run(1, 12'h081, 8'h01);
        for (n = 0; n < 300; n++) begin
            x = 12'($urandom);
            if (n % 3 == 0) x[11:6] = exec_pkg::SUB_OPCODE;
            if (n % 3 == 1) x[11:6] = exec_pkg::SWAP_OPCODE;
            if (x == exec_pkg::SLEEP_OPCODE) x = 12'h000;
            run($urandom % 8 != 0, x, 8'($urandom));
        end
        run(1, exec_pkg::SLEEP_OPCODE, 8'h00);
        run(1, 12'h0A1, 8'h55);
        run(1, 12'h381, 8'h55);
        // Reset in mid-run is the only way out of power-down
        rst_n = 1'b0;
        wk = 0;
        fl = 0;
        slp = 0;
        ps = 0;
        wd = 0;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        run(1, 12'h385, 8'hA5);
        run(1, 12'h080, 8'h5A);
        complete_run;
    end
endmodule // test_sleep_subtract_swap_exec

// File: verilog/exec_pkg.sv
// Package with encodings, flag positions and reset values for the executor
package exec_pkg;

    // ------------------------------------------------------------------
    // Instruction encodings
    // ------------------------------------------------------------------
    localparam logic [11:0] SLEEP_OPCODE  = 12'h003;
    localparam logic [5:0]  SUB_OPCODE    = 6'h02;
    localparam logic [5:0]  SWAP_OPCODE   = 6'h0E;
    localparam int          OPCODE_HI     = 11;
    localparam int          OPCODE_LO     = 6;
    localparam int          DEST_BIT      = 5;
    localparam int          FADDR_HI      = 4;

    // ------------------------------------------------------------------
    // Status flag positions (status byte layout)
    // ------------------------------------------------------------------
    localparam int CARRY_POS   = 0;
    localparam int DIGIT_POS   = 1;
    localparam int ZERO_POS    = 2;
    localparam int POWERDN_POS = 3;
    localparam int TIMEOUT_POS = 4;

    // ------------------------------------------------------------------
    // Reset and clear values
    // ------------------------------------------------------------------
    localparam logic [7:0] WATCHDOG_CLEAR  = 8'h00;
    localparam logic [7:0] PRESCALE_CLEAR  = 8'h00;
    localparam logic [7:0] WORK_RESET      = 8'h00;
    localparam logic [4:0] STATUS_RESET    = 5'h18;

    // ------------------------------------------------------------------
    // Carried types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [11:0] word;
        logic [7:0] file_data;
    } instr_s;

    typedef struct packed {
        logic       file_we;
        logic [4:0] file_addr;
        logic [7:0] file_data;
    } file_wr_s;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       digit;
        logic       zero;
    } alu_s;

endpackage

// File: verilog/sleep_subtract_swap_exec.sv
// Executor for power-down, subtract-from-file and nibble-swap instructions
// Operation
// RULE_01: Power-down clears watchdog counter and its prescaler to zero.
// RULE_02: Power-down sets active-low time-out flag to one.
// RULE_03: Power-down clears active-low power-down flag to zero.
// RULE_04: After power-down the oscillator halts; no further instructions run.
// RULE_05: Subtract computes file minus work, updating carry, digit-carry, zero.
// RULE_06: Subtract destination bit 0 writes work, 1 writes file register.
// RULE_07: Nibble swap exchanges the file register nibbles; flags stay unchanged.
// RULE_08: Swap destination bit 0 writes work, 1 writes file register.
// RULE_09: Subtract carry is one without borrow, zero on borrow.
`timescale 1ns/10ps
module sleep_subtract_swap_exec (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire exec_pkg::instr_s   instr_in,
    output exec_pkg::file_wr_s      file_wr,
    output logic [7:0]              work_reg,
    output logic                    carry_flag,
    output logic                    digit_carry_flag,
    output logic                    zero_flag,
    output logic                    timeout_flag_n,
    output logic                    powerdown_flag_n,
    output logic [7:0]              watchdog_counter,
    output logic [7:0]              watchdog_prescaler,
    output logic                    osc_run,
    output logic                    asleep
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    typedef enum {RUNNING, SLEEPING} core_state_e;
    core_state_e state_reg;

    logic        is_sleep;
    logic        is_sub;
    logic        is_swap;
    logic        dest_file;
    logic        go;
    exec_pkg::alu_s alu;

    // Nothing is accepted once asleep; wake-up belongs elsewhere
    assign go        = instr_in.valid && (state_reg == RUNNING); // RULE_04
    assign is_sleep  = go && (instr_in.word == exec_pkg::SLEEP_OPCODE);
    assign is_sub    = go && (instr_in.word[exec_pkg::OPCODE_HI:
                        exec_pkg::OPCODE_LO] == exec_pkg::SUB_OPCODE);
    assign is_swap   = go && (instr_in.word[exec_pkg::OPCODE_HI:
                        exec_pkg::OPCODE_LO] == exec_pkg::SWAP_OPCODE);
    assign dest_file = instr_in.word[exec_pkg::DEST_BIT];

    sub_swap_alu u_alu (
        .file_val (instr_in.file_data),
        .work_val (work_reg),
        .do_swap  (is_swap),
        .alu_out  (alu)
    );

    // ------------------------------------------------------------------
    // Core run state
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= RUNNING;
            osc_run   <= 1'b1;
            asleep    <= 1'b0;
        end else if (is_sleep) begin
            state_reg <= SLEEPING; // RULE_04
            osc_run   <= 1'b0;     // RULE_04
            asleep    <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog and prescaler clear
    // ------------------------------------------------------------------
    // The watchdog's own oscillator is not modelled: counting follows the
    // core clock and stops with it, so the cleared value holds while asleep
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_counter   <= exec_pkg::WATCHDOG_CLEAR;
            watchdog_prescaler <= exec_pkg::PRESCALE_CLEAR;
        end else if (is_sleep) begin
            watchdog_counter   <= exec_pkg::WATCHDOG_CLEAR; // RULE_01
            watchdog_prescaler <= exec_pkg::PRESCALE_CLEAR; // RULE_01
        end else if (state_reg == RUNNING) begin
            watchdog_prescaler <= 8'(watchdog_prescaler + 8'h01);
            // Counter steps once per full prescaler wrap
            if (&watchdog_prescaler) begin
                watchdog_counter <= 8'(watchdog_counter + 8'h01);
            end
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_flag       <= exec_pkg::STATUS_RESET[exec_pkg::CARRY_POS];
            digit_carry_flag <= exec_pkg::STATUS_RESET[exec_pkg::DIGIT_POS];
            zero_flag        <= exec_pkg::STATUS_RESET[exec_pkg::ZERO_POS];
            powerdown_flag_n <= exec_pkg::STATUS_RESET[exec_pkg::POWERDN_POS];
            timeout_flag_n   <= exec_pkg::STATUS_RESET[exec_pkg::TIMEOUT_POS];
        end else begin
            if (is_sleep) begin
                timeout_flag_n   <= 1'b1; // RULE_02
                powerdown_flag_n <= 1'b0; // RULE_03
            end
            // Swap leaves every flag alone
            if (is_sub) begin
                carry_flag       <= alu.carry; // RULE_05 RULE_09
                digit_carry_flag <= alu.digit; // RULE_05
                zero_flag        <= alu.zero;  // RULE_05
            end
        end
    end

    // ------------------------------------------------------------------
    // Result delivery
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg <= exec_pkg::WORK_RESET;
        end else if ((is_sub || is_swap) && !dest_file) begin
            work_reg <= alu.result; // RULE_06 RULE_08
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_wr <= '0;
        end else begin
            file_wr.file_we   <= (is_sub || is_swap)
                                 && dest_file; // RULE_06 RULE_08
            file_wr.file_addr <= instr_in.word[exec_pkg::FADDR_HI:0];
            file_wr.file_data <= alu.result;
        end
    end

endmodule // sleep_subtract_swap_exec

// File: verilog/sub_swap_alu.sv
// Combinational subtract and nibble-swap datapath
`timescale 1ns/10ps
module sub_swap_alu (
    input  wire logic [7:0]   file_val,
    input  wire logic [7:0]   work_val,
    input  wire logic         do_swap,
    output exec_pkg::alu_s    alu_out
);
    logic [8:0] diff;
    logic [4:0] low_diff;

    // Two's complement: f + ~w + 1, carry out is the no-borrow indication
    assign diff     = {1'b0, file_val} + {1'b0, ~work_val} + 9'h001; // RULE_05
    assign low_diff = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]}
                      + 5'h01;

    always_comb begin
        if (do_swap) begin
            alu_out.result = {file_val[3:0], file_val[7:4]}; // RULE_07
        end else begin
            alu_out.result = diff[7:0];
        end
        alu_out.carry = diff[8]; // RULE_09
        alu_out.digit = low_diff[4];
        alu_out.zero  = (diff[7:0] == 8'h00);
    end
endmodule // sub_swap_alu
